// ===== src/cst_timing.sv
// Instruction state-timing sequencer: decodes, costs and walks cycles.
// Assumes the word is held while i_instr_valid and the bus side
// reports whether data goes to a peripheral and whether it is slow.
`timescale 1ns/10ps
`include "cst_timing_regs.svh"

module cst_timing #(
  parameter logic [3:0] STATE_DIV = `CST_STATE_DIV
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr_word,
  input wire logic i_data_periph,
  input wire logic i_periph_slow,
  output logic o_instr_ready,
  output logic o_done,
  output logic o_busy,
  output cst_timing_pkg::cst_kind_t o_cycle_kind,
  output cst_timing_pkg::cst_class_t o_op_class,
  output logic o_alt_sel,
  output logic [7:0] o_total_states
);

  logic rst_meta_n;
  logic rst_n;
  logic [3:0] div_cnt;
  logic state_tick;
  cst_timing_pkg::cst_state_t state;
  cst_timing_pkg::cst_decode_t dec;
  cst_timing_pkg::cst_counts_t counts;
  cst_timing_pkg::cst_kind_t kind;
  logic [1:0] byte_cost;
  logic [1:0] word_cost;
  logic [1:0] st_cnt;
  logic [2:0] cyc_cnt;
  logic accept;
  logic cycle_end;
  logic kind_end;
  logic [2:0] next_k;
  logic [7:0] elapsed;

  // ----------------------------------------------------------
  // Reset release through two flops
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------
  // State divider: one tick per CPU state
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
    end else if (div_cnt >= STATE_DIV - 4'h1) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  assign state_tick = (div_cnt >= STATE_DIV - 4'h1);

  cst_decode cst_decode_inst (
    .i_word(i_instr_word),
    .o_dec(dec)
  );

  // ----------------------------------------------------------
  // Helpers: count and cost per kind
  // ----------------------------------------------------------
  function automatic logic [2:0] count_of(input cst_timing_pkg::cst_counts_t c,
                                          input logic [2:0] k);
    count_of = c[k*3 +: 3];
  endfunction

  function automatic logic [1:0] cost_of(input logic [2:0] k, input logic [1:0] bc,
                                         input logic [1:0] wc);
    unique case (k)
      3'h0: cost_of = `CST_S_FETCH; // see RULE_05
      3'h1: cost_of = `CST_S_BRANCH; // see RULE_06
      3'h2: cost_of = `CST_S_STACK; // see RULE_06
      3'h3: cost_of = bc;
      3'h4: cost_of = wc;
      default: cost_of = `CST_S_INTERNAL;
    endcase
  endfunction

  // Location picks byte cost; slow peripherals need the extra state
  function automatic logic [1:0] loc_cost(input logic peri, input logic slow);
    if (!peri) begin
      loc_cost = `CST_S_MEM_BYTE; // see RULE_05
    end else if (slow) begin
      loc_cost = `CST_S_PERI_SLOW; // see RULE_07
    end else begin
      loc_cost = `CST_S_PERI_FAST; // see RULE_07
    end
  endfunction

  // Sum of count times cost over all six kinds
  function automatic logic [7:0] total_of(input cst_timing_pkg::cst_counts_t c,
                                          input logic [1:0] bc, input logic [1:0] wc);
    logic [7:0] acc;
    acc = 8'h0;
    for (int k = 0; k < 6; k++) begin
      // Widen both factors first so the product cannot wrap at three bits
      acc = acc + 8'(count_of(c, 3'(k))) * 8'(cost_of(3'(k), bc, wc)); // see RULE_04
    end
    total_of = acc;
  endfunction

  // First later kind with cycles; 6 marks the end
  always_comb begin
    next_k = 3'h6;
    for (int k = 5; k >= 0; k--) begin
      if (3'(k) > kind && count_of(counts, 3'(k)) != 3'h0) begin
        next_k = 3'(k);
      end
    end
  end

  assign o_instr_ready = (state == cst_timing_pkg::CST_IDLE);
  assign accept = o_instr_ready & i_instr_valid;
  assign cycle_end = (state == cst_timing_pkg::CST_RUN) & state_tick &
                     (st_cnt == cost_of(kind, byte_cost, word_cost) - 2'h1);
  assign kind_end = cycle_end & (cyc_cnt == count_of(counts, kind) - 3'h1);
  assign o_busy = (state == cst_timing_pkg::CST_RUN);
  assign o_cycle_kind = kind;

  // ----------------------------------------------------------
  // Control: idle until a word, run until last cycle ends
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cst_timing_pkg::CST_IDLE;
    end else begin
      unique case (state)
        cst_timing_pkg::CST_IDLE: begin
          if (accept) begin
            state <= cst_timing_pkg::CST_RUN;
          end
        end
        cst_timing_pkg::CST_RUN: begin
          if (kind_end && next_k == 3'h6) begin
            state <= cst_timing_pkg::CST_IDLE; // see RULE_09
          end
        end
        default: state <= cst_timing_pkg::CST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Walk: states within a cycle, cycles within a kind, kinds in order
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind <= cst_timing_pkg::CST_K_FETCH;
      st_cnt <= 2'h0;
      cyc_cnt <= 3'h0;
    end else if (accept) begin
      kind <= cst_timing_pkg::CST_K_FETCH; // see RULE_09
      st_cnt <= 2'h0;
      cyc_cnt <= 3'h0;
    end else if (kind_end) begin
      if (next_k != 3'h6) begin
        kind <= cst_timing_pkg::cst_kind_t'(next_k); // see RULE_09
      end
      st_cnt <= 2'h0;
      cyc_cnt <= 3'h0;
    end else if (cycle_end) begin
      st_cnt <= 2'h0;
      cyc_cnt <= cyc_cnt + 3'h1;
    end else if (o_busy && state_tick) begin
      st_cnt <= st_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------
  // Latched decode and costs; location sampled once per instruction
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      counts <= '0;
      byte_cost <= `CST_S_MEM_BYTE;
      word_cost <= `CST_S_MEM_WORD;
      o_op_class <= cst_timing_pkg::CST_C_OTHER;
      o_alt_sel <= 1'b0;
      o_total_states <= 8'h0;
    end else if (accept) begin
      counts <= dec.counts;
      byte_cost <= loc_cost(i_data_periph, i_periph_slow);
      word_cost <= i_data_periph ? loc_cost(1'b1, i_periph_slow) : `CST_S_MEM_WORD;
      o_op_class <= dec.op_class;
      o_alt_sel <= dec.alt_sel;
      o_total_states <= total_of(dec.counts, loc_cost(i_data_periph, i_periph_slow),
        i_data_periph ? loc_cost(1'b1, i_periph_slow) : `CST_S_MEM_WORD); // see RULE_04
    end
  end

  // Done pulse marks the end of the last cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= kind_end && next_k == 3'h6;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed <= 8'h0;
    end else if (accept) begin
      elapsed <= 8'h0;
    end else if (o_busy && state_tick) begin
      elapsed <= elapsed + 8'h1;
    end
  end

  property p_total_matches;
    @(posedge i_clk) disable iff (!rst_n)
      o_done |-> (elapsed == o_total_states);
  endproperty
  a_total_matches: assert property (p_total_matches) // see RULE_04
    else $error("elapsed states differ from total");

  property p_vector_call;
    @(posedge i_clk) disable iff (!rst_n)
      (i_instr_word[15:8] == `CST_OP_CALL_VEC) |->
      (dec.counts.fetch == 3'h2 && dec.counts.branch == 3'h1 &&
       dec.counts.stack == 3'h1 && dec.counts.byte_acc == 3'h0 &&
       dec.counts.word_acc == 3'h0 && dec.counts.internal == 3'h0);
  endproperty
  a_vector_call: assert property (p_vector_call) // see RULE_08
    else $error("vector call cycle counts wrong");

  property p_vector_total;
    @(posedge i_clk) disable iff (!rst_n)
      (accept && i_instr_word[15:8] == `CST_OP_CALL_VEC) |=> (o_total_states == 8'h8);
  endproperty
  a_vector_total: assert property (p_vector_total) // see RULE_06
    else $error("vector call not eight states");

  property p_bitset_mem;
    @(posedge i_clk) disable iff (!rst_n)
      (accept && i_instr_word[15:8] == `CST_OP_BIT_WR_ABS && !i_data_periph)
      |=> (o_total_states == 8'h8);
  endproperty
  a_bitset_mem: assert property (p_bitset_mem) // see RULE_05
    else $error("bit set in memory not eight states");

  property p_peri_slow;
    @(posedge i_clk) disable iff (!rst_n)
      (accept && i_instr_word[15:8] == `CST_OP_BIT_WR_ABS && i_data_periph && i_periph_slow)
      |=> (o_total_states == 8'ha);
  endproperty
  a_peri_slow: assert property (p_peri_slow) // see RULE_07
    else $error("slow peripheral byte cost not three");

  property p_alt_select;
    @(posedge i_clk) disable iff (!rst_n)
      accept |=> (o_alt_sel == ($past(dec.alt_pos) & $past(i_instr_word[7])));
  endproperty
  a_alt_select: assert property (p_alt_select) // see RULE_02
    else $error("alternative select not from bit seven");

  property p_push_is_move;
    @(posedge i_clk) disable iff (!rst_n)
      (i_instr_word[15:8] == `CST_OP_STACK_MOVE) |->
      (dec.op_class == cst_timing_pkg::CST_C_DATA_MOVE);
  endproperty
  a_push_is_move: assert property (p_push_is_move) // see RULE_03
    else $error("stack push or pop not decoded as move");

  property p_fetch_first;
    @(posedge i_clk) disable iff (!rst_n)
      accept |=> (o_busy && kind == cst_timing_pkg::CST_K_FETCH && !o_instr_ready);
  endproperty
  a_fetch_first: assert property (p_fetch_first) // see RULE_09
    else $error("instruction did not start with fetch");

  property p_kind_order;
    @(posedge i_clk) disable iff (!rst_n)
      (o_busy && !accept) |=> (kind >= $past(kind) || o_instr_ready);
  endproperty
  a_kind_order: assert property (p_kind_order) // see RULE_09
    else $error("cycle kinds out of order");

endmodule

// ===== src/cst_timing_regs.svh
// Constants of the opcode decoder and state-timing sequencer.
// Assumes inclusion by bare name from the design modules cst_timing and cst_decode.
//
// Behaviour
// RULE_01: Opcode taken from word bits 15..8, two nibbles.
// RULE_02: Bit 7 selects between paired opcode alternatives.
// RULE_03: Push and pop decode as stack-pointer moves.
// RULE_04: Total states: sum of counts times costs.
// RULE_05: Fetch and on-chip byte access cost two.
// RULE_06: Branch read and stack cycle cost two.
// RULE_07: Peripheral byte access costs two or three.
// RULE_08: Indirect vector call: two fetch, one branch, one stack.
// RULE_09: Cycles run in order; next only when done.
`ifndef CST_TIMING_REGS_SVH
`define CST_TIMING_REGS_SVH

// ------------------------------------------------------------
// Per-cycle state costs
// ------------------------------------------------------------
`define CST_S_FETCH 2'h2
`define CST_S_BRANCH 2'h2
`define CST_S_STACK 2'h2
`define CST_S_MEM_BYTE 2'h2
`define CST_S_MEM_WORD 2'h2
`define CST_S_PERI_FAST 2'h2
`define CST_S_PERI_SLOW 2'h3
`define CST_S_INTERNAL 2'h1

// ------------------------------------------------------------
// Opcode positions (first byte)
// ------------------------------------------------------------
`define CST_OP_NOP 8'h00
`define CST_OP_SLEEP 8'h01
`define CST_OP_NOT_NEG 8'h17
`define CST_HI_BRANCH 4'h4
`define CST_OP_CALL_REG 8'h5d
`define CST_OP_CALL_ABS 8'h5e
`define CST_OP_CALL_VEC 8'h5f
`define CST_OP_MOVE_BIT 8'h67
`define CST_OP_STACK_MOVE 8'h6d
`define CST_OP_AND_BIT 8'h76
`define CST_OP_BIT_RD_REG 8'h7c
`define CST_OP_BIT_WR_REG 8'h7d
`define CST_OP_BIT_RD_ABS 8'h7e
`define CST_OP_BIT_WR_ABS 8'h7f

// ------------------------------------------------------------
// State divider default
// ------------------------------------------------------------
`define CST_STATE_DIV 4'h1

`endif

// ===== src/cst_timing_pkg.sv
// Types shared by the decoder and the sequencer.
// Assumes the constants header sits beside it.
package cst_timing_pkg;

  // ----------------------------------------------------------
  // Cycle kinds in execution order
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    CST_K_FETCH = 3'h0,
    CST_K_BRANCH = 3'h1,
    CST_K_STACK = 3'h2,
    CST_K_BYTE = 3'h3,
    CST_K_WORD = 3'h4,
    CST_K_INTERNAL = 3'h5
  } cst_kind_t;

  // Cycle counts of one instruction, indexed by kind
  typedef struct packed {
    logic [2:0] internal;
    logic [2:0] word_acc;
    logic [2:0] byte_acc;
    logic [2:0] stack;
    logic [2:0] branch;
    logic [2:0] fetch;
  } cst_counts_t;

  typedef enum logic [2:0] {
    CST_C_OTHER = 3'h0,
    CST_C_DATA_MOVE = 3'h1,
    CST_C_SUB_CALL = 3'h2,
    CST_C_BIT_SET = 3'h3,
    CST_C_BRANCH = 3'h4,
    CST_C_BIT_OTHER = 3'h5
  } cst_class_t;

  // Decoder result
  typedef struct packed {
    cst_class_t op_class;
    logic alt_pos;
    logic alt_sel;
    cst_counts_t counts;
  } cst_decode_t;

  typedef enum logic [1:0] {
    CST_IDLE = 2'b01,
    CST_RUN = 2'b10
  } cst_state_t;

endpackage

// ===== src/cst_decode.sv
// First-byte opcode decoder giving class and per-kind cycle counts.
// Assumes a held instruction word; purely combinational.
`timescale 1ns/10ps
`include "cst_timing_regs.svh"

module cst_decode (
  input wire logic [15:0] i_word,
  output cst_timing_pkg::cst_decode_t o_dec
);

  logic [3:0] op_hi;
  logic [3:0] op_lo;
  logic [7:0] op;

  // ----------------------------------------------------------
  // Opcode split
  // ----------------------------------------------------------
  assign op_hi = i_word[15:12]; // see RULE_01
  assign op_lo = i_word[11:8]; // see RULE_01
  assign op = {op_hi, op_lo};

  // Positions holding two instructions
  function automatic logic is_alt(input logic [7:0] code);
    is_alt = (code == `CST_OP_NOT_NEG) || (code == `CST_OP_MOVE_BIT) ||
             (code == `CST_OP_AND_BIT) || (code == `CST_OP_STACK_MOVE) ||
             (code[7:4] == 4'h7 && code[3:0] >= 4'h4 && code[3:0] <= 4'h7);
  endfunction

  // ----------------------------------------------------------
  // Class and cycle counts; unlisted codes are one-word register ops
  // ----------------------------------------------------------
  always_comb begin
    o_dec = '0;
    o_dec.counts.fetch = 3'h1;
    o_dec.op_class = cst_timing_pkg::CST_C_OTHER;
    o_dec.alt_pos = is_alt(op);
    o_dec.alt_sel = is_alt(op) & i_word[7]; // see RULE_02
    if (op_hi == `CST_HI_BRANCH) begin
      o_dec.op_class = cst_timing_pkg::CST_C_BRANCH;
      o_dec.counts.fetch = 3'h2;
    end else begin
      unique case (op)
        `CST_OP_CALL_VEC: begin
          o_dec.op_class = cst_timing_pkg::CST_C_SUB_CALL;
          o_dec.counts.fetch = 3'h2; // see RULE_08
          o_dec.counts.branch = 3'h1; // see RULE_08
          o_dec.counts.stack = 3'h1; // see RULE_08
        end
        `CST_OP_CALL_REG: begin
          o_dec.op_class = cst_timing_pkg::CST_C_SUB_CALL;
          o_dec.counts.fetch = 3'h2;
          o_dec.counts.stack = 3'h1;
        end
        `CST_OP_CALL_ABS: begin
          o_dec.op_class = cst_timing_pkg::CST_C_SUB_CALL;
          o_dec.counts.fetch = 3'h2;
          o_dec.counts.stack = 3'h1;
          o_dec.counts.internal = 3'h2;
        end
        // Push and pop have no code of their own: word move via stack pointer
        `CST_OP_STACK_MOVE: begin
          o_dec.op_class = cst_timing_pkg::CST_C_DATA_MOVE; // see RULE_03
          o_dec.counts.word_acc = 3'h1;
          o_dec.counts.internal = 3'h2;
        end
        `CST_OP_BIT_WR_REG, `CST_OP_BIT_WR_ABS: begin
          o_dec.op_class = cst_timing_pkg::CST_C_BIT_SET;
          o_dec.counts.fetch = 3'h2;
          o_dec.counts.byte_acc = 3'h2;
        end
        `CST_OP_BIT_RD_REG, `CST_OP_BIT_RD_ABS: begin
          o_dec.op_class = cst_timing_pkg::CST_C_BIT_OTHER;
          o_dec.counts.fetch = 3'h2;
          o_dec.counts.byte_acc = 3'h1;
        end
        default: begin
          if (op_hi == 4'h6 && op_lo >= 4'h8) begin
            o_dec.op_class = cst_timing_pkg::CST_C_DATA_MOVE; // see RULE_03
          end
        end
      endcase
    end
  end

endmodule

// ===== verification/cst_bus_model.sv
// Far-side model: on-chip memory and peripheral modules behind the bus.
// Assumes the bench picks the target of an instruction's data cycles.
`timescale 1ns/10ps

module cst_bus_model (
  input wire logic [1:0] i_sel,
  output logic o_data_periph,
  output logic o_periph_slow
);
  // ----------------------------------------------------------
  // Target decode
  // ----------------------------------------------------------
  // 0 memory, 1 two-state module, 2 three-state module
  // Wait count is fixed per module, so it follows the target alone
  assign o_data_periph = (i_sel != 2'h0);
  assign o_periph_slow = (i_sel == 2'h2);
endmodule

// ===== verification/cst_timing_tb.sv
// Self-checking bench for the state-timing sequencer.
// Assumes cst_timing, its package and the bus model are compiled first.
`timescale 1ns/10ps

module cst_timing_tb;
  logic i_clk;
  logic i_reset_n;
  logic i_instr_valid;
  logic [15:0] i_instr_word;
  logic [1:0] bus_sel;
  logic data_periph;
  logic periph_slow;
  logic o_instr_ready;
  logic o_done;
  logic o_busy;
  cst_timing_pkg::cst_kind_t o_cycle_kind;
  cst_timing_pkg::cst_class_t o_op_class;
  logic o_alt_sel;
  logic [7:0] o_total_states;
  int mismatches;
  int num_checks;
  int kc [6];

  // ----------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------
  cst_timing #(.STATE_DIV(4'h1)) cst_timing_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
    .i_instr_word(i_instr_word), .i_data_periph(data_periph),
    .i_periph_slow(periph_slow), .o_instr_ready(o_instr_ready), .o_done(o_done),
    .o_busy(o_busy), .o_cycle_kind(o_cycle_kind), .o_op_class(o_op_class),
    .o_alt_sel(o_alt_sel), .o_total_states(o_total_states)
  );

  cst_bus_model cst_bus_model_inst (
    .i_sel(bus_sel), .o_data_periph(data_periph), .o_periph_slow(periph_slow)
  );

  // Free-running 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  // One compare for every 8-bit or narrower result; ff means skip
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    if (exp !== 8'hff) begin
      num_checks++;
      if (got !== exp) begin
        mismatches++;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // Offers one word at a falling edge and walks it to its done pulse;
  // returns in the done cycle so the next word goes back-to-back
  task automatic run_op(input logic [15:0] w, input logic [1:0] sel, input logic [7:0] tot,
                        input logic [7:0] cls, input logic alt, input logic [7:0] fet);
    int n;
    logic [2:0] pk;
    pk = 3'h0;
    foreach (kc[k]) kc[k] = 0;
    bus_sel = sel;
    i_instr_word = w;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
    i_instr_valid = 1'b0;
    chk("ready_low", 8'h00, {7'h0, o_instr_ready});
    chk("total", tot, o_total_states);
    chk("class", cls, {5'h0, o_op_class});
    chk("alt_sel", {7'h0, alt}, {7'h0, o_alt_sel});
    n = 1;
    while (o_done !== 1'b1 && n < 300) begin
      if (o_busy === 1'b1) begin
        kc[o_cycle_kind]++;
        if (o_cycle_kind < pk) chk("kind_order", {5'h0, pk}, {5'h0, o_cycle_kind});
        pk = o_cycle_kind;
      end
      @(negedge i_clk);
      n++;
    end
    chk("done_cycle", tot + 8'h1, n[7:0]);
    chk("fetch_states", fet, kc[0][7:0]);
    chk("ready_again", 8'h01, {7'h0, o_instr_ready});
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Vector call: two fetches, one branch read, one stack cycle
  task automatic t_vector_call();
    run_op(16'h5f30, 2'h0, 8'h08, 8'h02, 1'b0, 8'h04);
    chk("branch_states", 8'h02, kc[1][7:0]);
    chk("stack_states", 8'h02, kc[2][7:0]);
    chk("data_states", 8'h00, kc[3][7:0] + kc[4][7:0] + kc[5][7:0]);
    @(negedge i_clk);
    chk("done_pulse", 8'h00, {7'h0, o_done});
    chk("ready_held", 8'h01, {7'h0, o_instr_ready});
    $display("test vector_call done");
  endtask

  // Bit write to memory, fast and slow modules, back to back
  task automatic t_byte_targets();
    run_op(16'h7f00, 2'h0, 8'h08, 8'h03, 1'b0, 8'h04);
    chk("byte_states_mem", 8'h04, kc[3][7:0]);
    run_op(16'h7f00, 2'h1, 8'h08, 8'hff, 1'b0, 8'h04);
    run_op(16'h7f00, 2'h2, 8'h0a, 8'hff, 1'b0, 8'h04);
    chk("byte_states_slow", 8'h06, kc[3][7:0]);
    $display("test byte_targets done");
  endtask

  // Push and pop share the move opcode; bit 7 picks the form
  task automatic t_stack_moves();
    run_op(16'h6d70, 2'h0, 8'h06, 8'h01, 1'b0, 8'h02);
    run_op(16'h6df0, 2'h0, 8'h06, 8'h01, 1'b1, 8'h02);
    run_op(16'h6df0, 2'h2, 8'h07, 8'h01, 1'b1, 8'h02);
    $display("test stack_moves done");
  endtask

  // Nibble split, paired positions and the other call forms
  task automatic t_opcode_map();
    run_op(16'h4080, 2'h0, 8'h04, 8'h04, 1'b0, 8'h04);
    run_op(16'h0080, 2'h0, 8'h02, 8'h00, 1'b0, 8'h02);
    run_op(16'h1780, 2'h0, 8'h02, 8'hff, 1'b1, 8'h02);
    run_op(16'h1700, 2'h0, 8'h02, 8'hff, 1'b0, 8'h02);
    run_op(16'h5d00, 2'h0, 8'h06, 8'h02, 1'b0, 8'h04);
    run_op(16'h5e00, 2'h0, 8'h08, 8'h02, 1'b0, 8'h04);
    run_op(16'h7e00, 2'h0, 8'h06, 8'h05, 1'b0, 8'h04);
    chk("byte_states_rd", 8'h02, kc[3][7:0]);
    run_op(16'h6800, 2'h0, 8'h02, 8'h01, 1'b0, 8'h02);
    $display("test opcode_map done");
  endtask

  // Reset in mid-instruction must drop the walk at once
  task automatic t_reset_midrun();
    bus_sel = 2'h0;
    i_instr_word = 16'h5f00;
    i_instr_valid = 1'b1;
    @(negedge i_clk);
    i_instr_valid = 1'b0;
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b0;
    #1;
    chk("rst_busy", 8'h00, {7'h0, o_busy});
    chk("rst_ready", 8'h01, {7'h0, o_instr_ready});
    chk("rst_total", 8'h00, o_total_states);
    chk("rst_done", 8'h00, {7'h0, o_done});
    chk("rst_kind", 8'h00, {5'h0, o_cycle_kind});
    chk("rst_class", 8'h00, {5'h0, o_op_class});
    chk("rst_alt", 8'h00, {7'h0, o_alt_sel});
    @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
    run_op(16'h0000, 2'h0, 8'h02, 8'h00, 1'b0, 8'h02);
    $display("test reset_midrun done");
  endtask

  // ----------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence: reset held ten cycles, inputs moved at falling edges
  initial begin
    mismatches = 0;
    num_checks = 0;
    i_reset_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr_word = 16'h0000;
    bus_sel = 2'h0;
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
    t_vector_call();
    t_byte_targets();
    t_stack_moves();
    t_opcode_map();
    t_reset_midrun();
    results();
  end

  // Watchdog: the run needs about 125 cycles, allow far more
  initial begin
    #(8 * 20000);
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    results();
  end
endmodule
